// *** hw/zero_cross_detect_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "zcd_defines.svh"
module zero_cross_detect_ctrl (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [1:0] SLEEP_MODE,
  input wire logic DETECTOR_RAW,
  output logic DETECTOR_ON,
  output logic DETECTOR_OUT,
  output logic PIN_OUT,
  output logic PIN_OE,
  output logic IRQ
);
  logic [7:0] control_ff;
  logic [7:0] nxt_control;
  logic [1:0] edge_sel_ff;
  logic [1:0] nxt_edge_sel;
  logic cross_ff;
  logic nxt_cross;
  logic prev_ff;
  logic nxt_prev;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic active;
  logic out_level;
  logic sync_level;
  logic rise;
  logic fall;
  logic hit;
  logic clear_req;
  logic wr_control;
  logic wr_irq_control;
  logic wr_status;
  logic rd_control;
  logic rd_irq_control;
  logic rd_status;
  logic [7:0] status_view;
  logic in_standby;
  logic in_power_down;
  logic irq_source_on;

  always_comb begin
    in_standby = 1'b0;
    in_power_down = 1'b0;
    case (zcd_pkg::sleep_mode_t'(SLEEP_MODE))
      zcd_pkg::SLEEP_STANDBY: in_standby = 1'b1;
      zcd_pkg::SLEEP_POWER_DOWN: in_power_down = 1'b1;
      default: in_standby = 1'b0;
    endcase
  end

  // Idle runs as active; only standby and power-down gate the detector.
  always_comb begin
    active = control_ff[`CTL_ENABLE_BIT];
    if (in_power_down) begin
      active = 1'b0;
    end else if (in_standby) begin
      active = active & control_ff[`CTL_STANDBY_BIT];
    end
  end

  // Gated output; inversion applies before every consumer.
  assign out_level = active & (DETECTOR_RAW ^ control_ff[`CTL_INVERT_BIT]);

  // Status and edge logic read only the last of the three flops.
  level_sync #(
    .STAGES(`SYNC_STAGES)
  ) u_sync (
    .clk(REF_CLK),
    .rst(RESET),
    .din(out_level),
    .dout(sync_level)
  );

  assign rise = sync_level & ~prev_ff;
  assign fall = ~sync_level & prev_ff;

  always_comb begin
    case (zcd_pkg::edge_select_t'(edge_sel_ff))
      zcd_pkg::EDGE_RISING: hit = rise;
      zcd_pkg::EDGE_FALLING: hit = fall;
      zcd_pkg::EDGE_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end

  // The unmapped offset raises none of these strobes.
  always_comb begin
    wr_control = 1'b0;
    wr_irq_control = 1'b0;
    wr_status = 1'b0;
    if (WR) begin
      if (ADDR == `OFS_DETECTOR_CONTROL) begin
        wr_control = 1'b1;
      end else if (ADDR == `OFS_CROSSING_IRQ_CONTROL) begin
        wr_irq_control = 1'b1;
      end else if (ADDR == `OFS_DETECTOR_STATUS) begin
        wr_status = 1'b1;
      end
    end
  end

  always_comb begin
    rd_control = 1'b0;
    rd_irq_control = 1'b0;
    rd_status = 1'b0;
    if (RD) begin
      if (ADDR == `OFS_DETECTOR_CONTROL) begin
        rd_control = 1'b1;
      end else if (ADDR == `OFS_CROSSING_IRQ_CONTROL) begin
        rd_irq_control = 1'b1;
      end else if (ADDR == `OFS_DETECTOR_STATUS) begin
        rd_status = 1'b1;
      end
    end
  end

  assign clear_req = wr_status & WDATA[`STS_CROSS_BIT];

  // Reserved control bits are dropped here so that they read back as zero.
  always_comb begin
    nxt_control = control_ff;
    if (wr_control) begin
      nxt_control = WDATA & `CONTROL_MASK;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      control_ff <= `CONTROL_RESET;
    end else begin
      control_ff <= nxt_control;
    end
  end

  always_comb begin
    nxt_edge_sel = edge_sel_ff;
    if (wr_irq_control) begin
      nxt_edge_sel = WDATA[1:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      edge_sel_ff <= `IRQ_CONTROL_RESET;
    end else begin
      edge_sel_ff <= nxt_edge_sel;
    end
  end

  // The previous synchronized sample is the reference for edge detection.
  always_comb begin
    nxt_prev = sync_level;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  always_comb begin
    nxt_cross = cross_ff;
    if (clear_req) begin
      nxt_cross = 1'b0;
    end
    if (hit) begin
      // An edge in the clearing cycle still wins.
      nxt_cross = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cross_ff <= 1'b0;
    end else begin
      cross_ff <= nxt_cross;
    end
  end

  always_comb begin
    status_view = 8'h00;
    status_view[`STS_STATE_BIT] = sync_level;
    status_view[`STS_CROSS_BIT] = cross_ff;
  end

  // Read data is zero unless a read strobe hits a mapped register.
  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_control) begin
      nxt_rdata = control_ff;
    end else if (rd_irq_control) begin
      nxt_rdata = {6'h00, edge_sel_ff};
    end else if (rd_status) begin
      nxt_rdata = status_view;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA = rdata_ff;
  assign DETECTOR_ON = active;
  assign DETECTOR_OUT = out_level;
  assign PIN_OE = active & control_ff[`CTL_PIN_DRIVE_BIT];
  assign PIN_OUT = PIN_OE & out_level;
  // A zero edge select disables the source and masks a pending flag.
  assign irq_source_on = (edge_sel_ff != zcd_pkg::EDGE_NONE);
  assign IRQ = cross_ff & irq_source_on;
endmodule : zero_cross_detect_ctrl
`default_nettype wire

// *** hw/zcd_defines.svh ***
// Contract
// - Control bit 3 inverts detector output before pin, state, edges.
// - Control bit 6 drives detector output onto its pin.
// - Control bit 7 keeps detector running in standby sleep.
// - Edge select: 0 none, 1 rising, 2 falling, 3 both.
// - Status bit 4 shows output after three-stage synchronizer.
// - Writing one to status bit 0 clears cross flag; zero ignored.
// - Selected edge on inverted output sets the cross flag.
// - Interrupt request high while source enabled and flag set.
// - Power-down sleep disables detector and pin output entirely.
`ifndef ZCD_DEFINES_SVH
`define ZCD_DEFINES_SVH
`define OFS_DETECTOR_CONTROL 2'h0
`define OFS_CROSSING_IRQ_CONTROL 2'h2
`define OFS_DETECTOR_STATUS 2'h3
`define CTL_ENABLE_BIT 0
`define CTL_INVERT_BIT 3
`define CTL_PIN_DRIVE_BIT 6
`define CTL_STANDBY_BIT 7
`define STS_CROSS_BIT 0
`define STS_STATE_BIT 4
`define CONTROL_RESET 8'h00
`define IRQ_CONTROL_RESET 2'h0
`define CONTROL_MASK 8'hc9
`define SYNC_STAGES 3
`endif

// *** hw/zcd_pkg.sv ***
package zcd_pkg;
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISING = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_select_t;
  typedef enum logic [1:0] {
    SLEEP_ACTIVE = 2'b00,
    SLEEP_IDLE = 2'b01,
    SLEEP_STANDBY = 2'b10,
    SLEEP_POWER_DOWN = 2'b11
  } sleep_mode_t;
endpackage : zcd_pkg

// *** hw/level_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int STAGES = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic [STAGES-1:0] stage_ff;
  logic [STAGES-1:0] nxt_stage;

  always_comb begin
    nxt_stage = {stage_ff[STAGES-2:0], din};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  assign dout = stage_ff[STAGES-1];
endmodule : level_sync
`default_nettype wire

// *** test/zcd_comp_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module zcd_comp_model (
  input wire logic on,
  input wire logic lvl,
  output logic raw
);
  // An unpowered comparator gives no valid level, so show the inverse.
  assign raw = on ? lvl : ~lvl;
endmodule : zcd_comp_model
`default_nettype wire

// *** test/zcd_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module zcd_monitor (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic [1:0] SLEEP_MODE,
  input wire logic DETECTOR_ON,
  input wire logic DETECTOR_OUT,
  input wire logic PIN_OUT,
  input wire logic PIN_OE,
  input wire logic IRQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  en_off_a: assert property (WR && ADDR == 2'h0 && !WDATA[0] |=>
    !DETECTOR_ON && !DETECTOR_OUT) else $error("detector not gated off");
  stby_off_a: assert property (WR && ADDR == 2'h0 && !WDATA[7]
    ##1 SLEEP_MODE == 2'h2 |-> !DETECTOR_ON) else $error("standby on");
  pd_off_a: assert property (SLEEP_MODE == 2'h3 |->
    !DETECTOR_ON && !PIN_OE) else $error("power-down not off");
  pin_val_a: assert property (PIN_OE |->
    PIN_OUT == DETECTOR_OUT) else $error("pin value wrong");
  pin_off_a: assert property (WR && ADDR == 2'h0 && !WDATA[6] |=>
    !PIN_OE) else $error("pin driven");
  irq_hold_a: assert property (IRQ && !WR |=> IRQ)
    else $error("request dropped");
  irq_none_a: assert property (WR && ADDR == 2'h2 &&
    WDATA[1:0] == 2'h0 |=> !IRQ) else $error("request with no edges");
  state_sync_a: assert property (RD && ADDR == 2'h3 |=>
    RDATA[4] == $past(DETECTOR_OUT, 4)) else $error("state bit wrong");
  cover property (IRQ);
  cover property (PIN_OE && PIN_OUT);
  cover property (RD && ADDR == 2'h3);
endmodule : zcd_monitor
`default_nettype wire

// *** test/tb_zero_cross_detect_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_zero_cross_detect_ctrl;
  logic REF_CLK = 0, RESET = 1, WR = 0, RD = 0, lvl = 0, on, raw;
  logic [1:0] ADDR = 0, SLEEP_MODE = 0;
  logic [7:0] WDATA = 0, RDATA, d;
  logic out, pin, oe, IRQ;
  int err_count = 0, checked = 0, cyc = 0;
  always #20 REF_CLK = ~REF_CLK;
  zcd_comp_model i_comp (.on(on), .lvl(lvl), .raw(raw));
  zero_cross_detect_ctrl i_dut (.REF_CLK(REF_CLK), .RESET(RESET),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SLEEP_MODE(SLEEP_MODE), .DETECTOR_RAW(raw), .DETECTOR_ON(on),
    .DETECTOR_OUT(out), .PIN_OUT(pin), .PIN_OE(oe), .IRQ(IRQ));
  task w(input int n); repeat (n) @(posedge REF_CLK); #1; endtask : w
  task wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge REF_CLK) {WR, ADDR, WDATA} <= {1'b1, a, v};
    @(posedge REF_CLK) WR <= 0;
  endtask : wr
  task rd(input logic [1:0] a);
    @(posedge REF_CLK) {RD, ADDR} <= {1'b1, a};
    @(posedge REF_CLK) RD <= 0;
    #1 d = RDATA;
  endtask : rd
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task test_done;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      test_done;
    end
  end
  initial begin
    w(19);
    @(posedge REF_CLK) RESET <= 0;
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0]);
      chk("reset", 8'h00, d);
    end
    wr(2'h1, 8'hff);
    rd(2'h1);
    chk("unmapped", 8'h00, d);
    wr(2'h0, 8'hff);
    rd(2'h0);
    chk("ctl", 8'hc9, d);
    wr(2'h0, 8'h41);
    $display("T regs done");
    for (int m = 0; m < 4; m++) begin
      wr(2'h2, m[7:0]);
      wr(2'h3, 8'h01);
      @(posedge REF_CLK) lvl <= 1;
      w(8);
      chk("rise", m[0], IRQ);
      chk("pin", 8'h01, pin);
      wr(2'h3, 8'h00);
      w(1);
      chk("keep", m[0], IRQ);
      wr(2'h3, 8'h01);
      w(1);
      chk("clear", 8'h00, IRQ);
      @(posedge REF_CLK) lvl <= 0;
      w(8);
      chk("fall", m[1], IRQ);
      wr(2'h3, 8'h01);
    end
    $display("T edges done");
    wr(2'h0, 8'h49);
    w(1);
    chk("inv", 8'h01, out);
    w(4);
    rd(2'h3);
    chk("state", 8'h11, d);
    @(posedge REF_CLK) SLEEP_MODE <= 2'h2;
    w(1);
    chk("stby", 8'h00, on);
    wr(2'h0, 8'h09);
    w(1);
    chk("stby_wr", 8'h00, on);
    wr(2'h0, 8'hc9);
    w(1);
    chk("stby_run", 8'h01, on);
    @(posedge REF_CLK) SLEEP_MODE <= 2'h3;
    w(1);
    chk("pd", 8'h00, oe);
    chk("pd_on", 8'h00, on);
    @(posedge REF_CLK) SLEEP_MODE <= 2'h1;
    w(1);
    chk("idle", 8'h01, on);
    chk("idle_pin", 8'h01, oe);
    wr(2'h0, 8'h09);
    w(1);
    chk("pin_off", 8'h00, oe);
    chk("pin_off_on", 8'h01, on);
    wr(2'h0, 8'h48);
    w(1);
    chk("off", 8'h00, on);
    chk("off_out", 8'h00, out);
    $display("T sleep done");
    test_done;
  end
endmodule : tb_zero_cross_detect_ctrl
bind zero_cross_detect_ctrl zcd_monitor i_mon (.REF_CLK(REF_CLK),
  .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .SLEEP_MODE(SLEEP_MODE), .DETECTOR_ON(DETECTOR_ON),
  .DETECTOR_OUT(DETECTOR_OUT), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .IRQ(IRQ));
`default_nettype wire
